/* File: tps_clock_synth.v */
// three-loop clock synthesizer control logic with register port
`timescale 1ns/1ps
`default_nettype none
`include "tps_clock_synth_map.vh"

module tps_clock_synth #(
  parameter LOCK_CYC = `TPS_LOCK_TIME_US * `TPS_MCLK_KHZ / 1000,
  parameter AW = 8
) (
  input wire mclk,                 // 25 MHz reference clock
  input wire resetn,               // synchronous reset, active low
  input wire [AW-1:0] reg_addr,    // register byte address
  input wire [31:0] reg_wdata,     // register write data
  input wire reg_wr,               // write strobe
  input wire reg_rd,               // read strobe
  output wire [31:0] reg_rdata,    // read data, cycle after strobe
  input wire gp_ctrl_in,           // general-purpose control pin
  output wire clock_out_a,         // clock output a
  output wire clock_out_a_oe,      // clock output a drive enable
  output wire clock_out_b,         // clock output b
  output wire clock_out_b_oe,      // clock output b drive enable
  output wire clock_out_c,         // clock output c
  output wire clock_out_c_oe,      // clock output c drive enable
  output wire osc_enable,          // reference oscillator enable
  output wire xtal_load_en,        // on-die load caps connected
  output wire [5:0] xtal_load,     // load capacitance code
  output wire [1:0] xtal_drive,    // oscillator inverter strength
  output wire [2:0] loop_locked    // loop lock qualifiers
);

  localparam PS = `TPS_PSCALE_BITS;
  localparam [23:0] LOCK_LAST = LOCK_CYC - 1;

  // ***********************************
  // helper functions
  // ***********************************
  // limit of the phase accumulator for a pre-divider value
  function [19:0] loop_limit;
    input [7:0] q;
    begin
      loop_limit = {1'b0, ((q == 8'h00) ? 8'h01 : q), {PS{1'b0}}};
    end
  endfunction

  function [6:0] eff_div;
    input [6:0] d;
    begin
      eff_div = (d == 7'h00) ? 7'h01 : d;
    end
  endfunction

  function [6:0] half_div;
    input [6:0] d;
    reg [7:0] s;
    begin
      s = {1'b0, d} + 8'h01;
      half_div = s[7:1];
    end
  endfunction

  // ***********************************
  // configuration registers
  // ***********************************
  reg run_q;
  reg [1:0] mode_q;
  reg susp_also_q;
  reg bypass_q;
  reg [1:0] drive_q;
  reg [5:0] load_q;
  reg [18:0] l1s0_q;
  reg [18:0] l1s1_q;
  reg [18:0] l2_q;
  reg [18:0] l3_q;
  reg [18:0] outa_q;
  reg [18:0] outb_q;
  reg [18:0] outc_q;
  reg [6:0] susp_q;
  reg [31:0] rdata_q;

  wire cfg_wr;
  assign cfg_wr = reg_wr & ~run_q;

  always @(posedge mclk) begin
    if (!resetn) begin
      run_q <= 1'b0;
      mode_q <= `TPS_MODE_FS;
      susp_also_q <= 1'b0;
      bypass_q <= 1'b0;
      drive_q <= 2'h0;
      load_q <= `TPS_RST_LOAD;
      l1s0_q <= `TPS_RST_LOOP;
      l1s1_q <= `TPS_RST_LOOP;
      l2_q <= `TPS_RST_LOOP;
      l3_q <= `TPS_RST_LOOP;
      outa_q <= `TPS_RST_OUT;
      outb_q <= `TPS_RST_OUT;
      outc_q <= `TPS_RST_OUT;
      susp_q <= `TPS_RST_SUSP;
    end else begin
      if (reg_wr && reg_addr == `TPS_OFF_CTRL) begin
        run_q <= reg_wdata[`TPS_CTRL_RUN];
      end
      if (cfg_wr) begin
        case (reg_addr)
          `TPS_OFF_CTRL: begin
            mode_q <= reg_wdata[`TPS_CTRL_MODE_HI:`TPS_CTRL_MODE_LO];
            susp_also_q <= reg_wdata[`TPS_CTRL_SUSP_ALSO];
            bypass_q <= reg_wdata[`TPS_CTRL_BYPASS];
            drive_q <= reg_wdata[`TPS_CTRL_DRV_HI:`TPS_CTRL_DRV_LO];
          end
          `TPS_OFF_XTAL: load_q <= reg_wdata[5:0];
          `TPS_OFF_L1S0: l1s0_q <= reg_wdata[18:0];
          `TPS_OFF_L1S1: l1s1_q <= reg_wdata[18:0];
          `TPS_OFF_L2: l2_q <= reg_wdata[18:0];
          `TPS_OFF_L3: l3_q <= reg_wdata[18:0];
          `TPS_OFF_OUTA: outa_q <= {reg_wdata[18:16], 1'b0,
                                    reg_wdata[14:8], 1'b0, reg_wdata[6:0]};
          `TPS_OFF_OUTB: outb_q <= {reg_wdata[18:16], 1'b0,
                                    reg_wdata[14:8], 1'b0, reg_wdata[6:0]};
          `TPS_OFF_OUTC: outc_q <= {reg_wdata[18:16], 9'h000,
                                    reg_wdata[6:0]};
          `TPS_OFF_SUSP: susp_q <= {reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
          default: begin
          end
        endcase
      end
    end
  end

  // ***********************************
  // control pin synchroniser and decode
  // ***********************************
  reg gp_s1_q;
  reg gp_s2_q;
  reg fs_prev_q;
  wire fs_lvl;
  wire shut_act;
  wire stop_all;
  wire oe_off;
  wire susp_act;

  always @(posedge mclk) begin
    if (!resetn) begin
      gp_s1_q <= 1'b1;
      gp_s2_q <= 1'b1;
      fs_prev_q <= 1'b0;
    end else begin
      gp_s1_q <= gp_ctrl_in;
      gp_s2_q <= gp_s1_q;
      fs_prev_q <= fs_lvl;
    end
  end

  assign fs_lvl = (mode_q == `TPS_MODE_FS) & gp_s2_q;
  assign shut_act = (mode_q == `TPS_MODE_SHUT) & ~gp_s2_q;
  assign stop_all = ~run_q | shut_act;
  assign oe_off = (mode_q == `TPS_MODE_OE) & ~gp_s2_q;
  assign susp_act = ~gp_s2_q & ((mode_q == `TPS_MODE_SUSP) | susp_also_q);

  // ***********************************
  // synthesizer loops
  // ***********************************
  wire [18:0] loop_cfg0;
  assign loop_cfg0 = fs_lvl ? l1s1_q : l1s0_q;

  reg [19:0] acc_q [0:2];
  reg [23:0] lock_cnt_q [0:2];
  reg [2:0] tick_q;
  reg [2:0] lock_q;
  reg [19:0] acc_d [0:2];
  reg [2:0] tick_d;
  reg [2:0] loop_stop;
  reg [2:0] relock;
  reg [18:0] cfg;
  reg [19:0] sum;
  reg [19:0] lim;
  integer i;
  integer k;

  always @* begin
    cfg = 19'h00000;
    sum = 20'h00000;
    lim = 20'h00000;
    relock = 3'h0;
    // loop one relocks on a new setting
    relock[0] = fs_lvl ^ fs_prev_q;
    for (i = 0; i < 3; i = i + 1) begin
      case (i)
        0: cfg = loop_cfg0;
        1: cfg = l2_q;
        default: cfg = l3_q;
      endcase
      // suspended loops in the set stop
      loop_stop[i] = stop_all | (susp_act & susp_q[i]);
      sum = acc_q[i] + {1'b0, cfg[`TPS_LOOP_P_HI:`TPS_LOOP_P_LO]};
      lim = loop_limit(cfg[`TPS_LOOP_Q_HI:`TPS_LOOP_Q_LO]);
      if (sum >= lim) begin
        acc_d[i] = sum - lim;
        tick_d[i] = 1'b1;
      end else begin
        acc_d[i] = sum;
        tick_d[i] = 1'b0;
      end
    end
  end

  always @(posedge mclk) begin
    if (!resetn) begin
      for (k = 0; k < 3; k = k + 1) begin
        acc_q[k] <= 20'h00000;
        lock_cnt_q[k] <= 24'h000000;
      end
      tick_q <= 3'h0;
      lock_q <= 3'h0;
    end else begin
      for (k = 0; k < 3; k = k + 1) begin
        // a stopped loop clears all its logic
        if (loop_stop[k]) begin
          acc_q[k] <= 20'h00000;
          lock_cnt_q[k] <= 24'h000000;
          tick_q[k] <= 1'b0;
          lock_q[k] <= 1'b0;
        end else begin
          acc_q[k] <= acc_d[k];
          tick_q[k] <= tick_d[k];
          if (relock[k]) begin
            lock_cnt_q[k] <= 24'h000000;
            lock_q[k] <= 1'b0;
          end else if (lock_cnt_q[k] >= LOCK_LAST) begin
            lock_q[k] <= 1'b1;
          end else begin
            lock_cnt_q[k] <= lock_cnt_q[k] + 24'h000001;
          end
        end
      end
    end
  end

  // ***********************************
  // crosspoint and post dividers
  // ***********************************
  reg [6:0] cnt_q [0:2];
  reg [6:0] cur_q [0:2];
  reg [2:0] out_q;
  reg [2:0] oe_q;
  reg [2:0] src_ok;
  reg [2:0] src_tk;
  reg [2:0] inv;
  reg [2:0] out_susp;
  reg [6:0] new_div [0:2];
  reg [18:0] ocfg;
  reg [1:0] sel;
  integer j;
  integer m;

  always @* begin
    ocfg = 19'h00000;
    sel = 2'h0;
    for (j = 0; j < 3; j = j + 1) begin
      case (j)
        0: ocfg = outa_q;
        1: ocfg = outb_q;
        default: ocfg = outc_q;
      endcase
      sel = ocfg[`TPS_OUT_SRC_HI:`TPS_OUT_SRC_LO];
      case (sel)
        2'h0: begin
          src_ok[j] = ~stop_all;
          src_tk[j] = 1'b1;
        end
        2'h1: begin
          src_ok[j] = lock_q[0];
          src_tk[j] = tick_q[0];
        end
        2'h2: begin
          src_ok[j] = lock_q[1];
          src_tk[j] = tick_q[1];
        end
        default: begin
          src_ok[j] = lock_q[2];
          src_tk[j] = tick_q[2];
        end
      endcase
      inv[j] = ocfg[`TPS_OUT_INV];
      // select level picks a or b divider
      if (j < 2 && fs_lvl) begin
        new_div[j] = eff_div(ocfg[`TPS_OUT_DIV1_HI:`TPS_OUT_DIV1_LO]);
      end else begin
        new_div[j] = eff_div(ocfg[`TPS_OUT_DIV0_HI:`TPS_OUT_DIV0_LO]);
      end
      out_susp[j] = susp_act & susp_q[`TPS_SUSP_OUT_LO + j];
    end
  end

  always @(posedge mclk) begin
    if (!resetn) begin
      for (m = 0; m < 3; m = m + 1) begin
        cnt_q[m] <= 7'h00;
        cur_q[m] <= 7'h01;
      end
      out_q <= 3'h0;
      oe_q <= 3'h0;
    end else begin
      for (m = 0; m < 3; m = m + 1) begin
        if (!src_ok[m]) begin
          cnt_q[m] <= 7'h00;
          cur_q[m] <= new_div[m];
        end else if (src_tk[m]) begin
          // new divider taken at period end
          if (cnt_q[m] + 7'h01 >= cur_q[m]) begin
            cnt_q[m] <= 7'h00;
            cur_q[m] <= new_div[m];
          end else begin
            cnt_q[m] <= cnt_q[m] + 7'h01;
          end
        end
        out_q[m] <= src_ok[m] & ((cnt_q[m] < half_div(cur_q[m])) ^ inv[m]);
        oe_q[m] <= ~stop_all & ~oe_off & ~out_susp[m];
      end
    end
  end

  // ***********************************
  // crystal oscillator controls
  // ***********************************
  reg osc_en_q;
  reg load_en_q;
  reg [5:0] load_out_q;
  reg [1:0] drive_out_q;

  always @(posedge mclk) begin
    if (!resetn) begin
      osc_en_q <= 1'b0;
      load_en_q <= 1'b0;
      load_out_q <= 6'h00;
      drive_out_q <= 2'h0;
    end else begin
      osc_en_q <= ~shut_act;
      load_en_q <= ~bypass_q & ~shut_act;
      // load code passed to cap bank
      load_out_q <= bypass_q ? 6'h00 : load_q;
      drive_out_q <= drive_q;
    end
  end

  // ***********************************
  // register read port
  // ***********************************
  always @(posedge mclk) begin
    if (!resetn) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `TPS_OFF_CTRL: rdata_q <= {25'h0000000, drive_q, bypass_q,
                                  susp_also_q, mode_q, run_q};
        `TPS_OFF_XTAL: rdata_q <= {26'h0000000, load_q};
        `TPS_OFF_L1S0: rdata_q <= {13'h0000, l1s0_q};
        `TPS_OFF_L1S1: rdata_q <= {13'h0000, l1s1_q};
        `TPS_OFF_L2: rdata_q <= {13'h0000, l2_q};
        `TPS_OFF_L3: rdata_q <= {13'h0000, l3_q};
        `TPS_OFF_OUTA: rdata_q <= {13'h0000, outa_q};
        `TPS_OFF_OUTB: rdata_q <= {13'h0000, outb_q};
        `TPS_OFF_OUTC: rdata_q <= {13'h0000, outc_q};
        `TPS_OFF_SUSP: rdata_q <= {25'h0000000, susp_q};
        `TPS_OFF_STAT: rdata_q <= {24'h000000, fs_lvl, gp_s2_q, susp_act,
                                  shut_act, 1'b0, lock_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign reg_rdata = rdata_q;
  assign clock_out_a = out_q[0];
  assign clock_out_b = out_q[1];
  assign clock_out_c = out_q[2];
  assign clock_out_a_oe = oe_q[0];
  assign clock_out_b_oe = oe_q[1];
  assign clock_out_c_oe = oe_q[2];
  assign osc_enable = osc_en_q;
  assign xtal_load_en = load_en_q;
  assign xtal_load = load_out_q;
  assign xtal_drive = drive_out_q;
  assign loop_locked = lock_q;

endmodule // tps_clock_synth

`default_nettype wire

/* File: tps_clock_synth_map.vh */
// register map, field positions, reset values and timing of the clock synth
// Notes on behaviour
// - each loop runs at ref times P over 2048 Q
// - loop one may follow frequency select
// - control pin takes one of four functions
// - select level picks one of two settings
// - divider changes land only on period boundaries
// - suspend may act beside the main function
// - output enable low tri-states every output
// - shutdown low stops loops, oscillator, outputs
// - loops relock after leaving shutdown
// - crystal drive strength is configurable
// - six-bit load capacitance, 0.375 pF steps
// - driven reference bypasses load caps; feedback floats
// - crosspoint routes four sources to three outputs
// - each output has seven-bit post divider
// - outputs A, B two dividers; C one
// - suspend low stops a configured set
// - suspended loop stops; suspended output tri-states
// - output may take inverted loop phase
// - loop counted locked 3 ms after start
`ifndef TPS_CLOCK_SYNTH_MAP_VH
`define TPS_CLOCK_SYNTH_MAP_VH

// ***********************************
// register offsets (byte addresses)
// ***********************************
`define TPS_OFF_CTRL 8'h00
`define TPS_OFF_XTAL 8'h04
`define TPS_OFF_L1S0 8'h08
`define TPS_OFF_L1S1 8'h0C
`define TPS_OFF_L2 8'h10
`define TPS_OFF_L3 8'h14
`define TPS_OFF_OUTA 8'h18
`define TPS_OFF_OUTB 8'h1C
`define TPS_OFF_OUTC 8'h20
`define TPS_OFF_SUSP 8'h24
`define TPS_OFF_STAT 8'h28

// ***********************************
// field positions
// ***********************************
`define TPS_CTRL_RUN 0
`define TPS_CTRL_MODE_LO 1
`define TPS_CTRL_MODE_HI 2
`define TPS_CTRL_SUSP_ALSO 3
`define TPS_CTRL_BYPASS 4
`define TPS_CTRL_DRV_LO 5
`define TPS_CTRL_DRV_HI 6
`define TPS_LOOP_Q_LO 0
`define TPS_LOOP_Q_HI 7
`define TPS_LOOP_P_LO 8
`define TPS_LOOP_P_HI 18
`define TPS_OUT_DIV0_LO 0
`define TPS_OUT_DIV0_HI 6
`define TPS_OUT_DIV1_LO 8
`define TPS_OUT_DIV1_HI 14
`define TPS_OUT_SRC_LO 16
`define TPS_OUT_SRC_HI 17
`define TPS_OUT_INV 18
`define TPS_SUSP_OUT_LO 4

// ***********************************
// control pin functions
// ***********************************
`define TPS_MODE_FS 2'h0
`define TPS_MODE_SUSP 2'h1
`define TPS_MODE_OE 2'h2
`define TPS_MODE_SHUT 2'h3

// ***********************************
// reset values
// ***********************************
`define TPS_RST_LOOP 19'h00101
`define TPS_RST_OUT 19'h00101
`define TPS_RST_LOAD 6'h00
`define TPS_RST_SUSP 7'h00

// ***********************************
// timing
// ***********************************
`define TPS_MCLK_KHZ 25000
`define TPS_LOCK_TIME_US 3000
`define TPS_PSCALE_BITS 11

`endif

/* File: tps_sys_partner.sv */
// model of the system logic that drives the control pin
`timescale 1ns/1ps
`default_nettype none
module tps_sys_partner (
  input wire logic level_req, // level asked for by the bench
  output logic gp_ctrl_in     // control pin, asynchronous to mclk
);
  // ****
  // pin driver
  // ****
  initial gp_ctrl_in = 1'b1;
  // legal settings only
  // pin moves off the clock edge, like a board-level signal
  always @(level_req) begin
    gp_ctrl_in <= #7 level_req;
  end
endmodule // tps_sys_partner
`default_nettype wire

/* File: tps_clock_synth_props.sv */
// assertion checker for the clock synth control ports
`timescale 1ns/1ps
`default_nettype none
module tps_clock_synth_props #(
  parameter LOCK_CYC = 20
) (
  input wire mclk,             // reference clock
  input wire resetn,           // sync reset, active low
  input wire reg_wr,           // write strobe
  input wire reg_rd,           // read strobe
  input wire [31:0] reg_rdata, // read data
  input wire clock_out_a_oe,   // output a enable
  input wire clock_out_b_oe,   // output b enable
  input wire clock_out_c_oe,   // output c enable
  input wire osc_enable,       // oscillator enable
  input wire xtal_load_en,     // load caps connected
  input wire [5:0] xtal_load,  // load code
  input wire [1:0] xtal_drive, // inverter strength
  input wire [2:0] loop_locked // lock flags
);
  // ****
  // oscillator run time
  // ****
  logic [31:0] up_q;
  logic [31:0] up_d;
  assign up_d = (!resetn || !osc_enable) ? 32'h0 : up_q + 32'h1;
  always @(posedge mclk) begin
    up_q <= up_d;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ****
  // properties
  // ****
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data without a read");
  a_shut_tristate: assert property (
    !osc_enable |-> {clock_out_a_oe, clock_out_b_oe, clock_out_c_oe} == 3'h0)
    else $error("output driven while oscillator off");
  a_shut_unlock: assert property (
    !osc_enable |-> loop_locked == 3'h0)
    else $error("lock held while oscillator off");
  a_shut_caps: assert property (
    !osc_enable |-> !xtal_load_en)
    else $error("load caps on while oscillator off");
  a_lock_early: assert property (
    (loop_locked & ~$past(loop_locked)) != 3'h0 |-> up_q >= LOCK_CYC - 1)
    else $error("lock flag before lock time");
  a_relock_wait: assert property (
    $rose(osc_enable) |-> (loop_locked == 3'h0) [*8])
    else $error("lock flag right after wake");
  a_bypass_code: assert property (
    osc_enable && !xtal_load_en |-> xtal_load == 6'h00)
    else $error("load code nonzero in bypass");
  a_drive_written: assert property (
    $changed(xtal_drive) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("drive strength moved without a write");
endmodule // tps_clock_synth_props
bind tps_clock_synth tps_clock_synth_props #(.LOCK_CYC(LOCK_CYC)) u_props (
  .mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .clock_out_a_oe(clock_out_a_oe),
  .clock_out_b_oe(clock_out_b_oe), .clock_out_c_oe(clock_out_c_oe),
  .osc_enable(osc_enable), .xtal_load_en(xtal_load_en),
  .xtal_load(xtal_load), .xtal_drive(xtal_drive), .loop_locked(loop_locked)
);
`default_nettype wire

/* File: tps_clock_synth_bench.sv */
// self-checking bench for the clock synth control block
`timescale 1ns/1ps
`default_nettype none
module tps_clock_synth_bench;
  localparam int LOCK_CYC = 20;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pin_req = 1'b1;
  wire [31:0] reg_rdata;
  wire gp_ctrl_in, clock_out_a, clock_out_a_oe, clock_out_b_oe;
  wire clock_out_c_oe, osc_enable, xtal_load_en, clock_out_b, clock_out_c;
  wire [5:0] xtal_load;
  wire [1:0] xtal_drive;
  wire [2:0] loop_locked;
  int n_errors = 0;
  int checks_done = 0;
  int per;
  logic [31:0] rd_v;
  logic [7:0] ra [6] = '{8'h00, 8'h08, 8'h18, 8'h20, 8'h24, 8'h30};
  logic [31:0] rv [6] = '{32'h0, 32'h101, 32'h101, 32'h101, 32'h0, 32'h0};
  always #20 mclk = ~mclk;
  tps_clock_synth #(.LOCK_CYC(LOCK_CYC)) tps_clock_synth_inst (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .gp_ctrl_in(gp_ctrl_in),
    .clock_out_a(clock_out_a), .clock_out_a_oe(clock_out_a_oe),
    .clock_out_b(clock_out_b), .clock_out_b_oe(clock_out_b_oe),
    .clock_out_c(clock_out_c),
    .clock_out_c_oe(clock_out_c_oe), .osc_enable(osc_enable),
    .xtal_load_en(xtal_load_en), .xtal_load(xtal_load),
    .xtal_drive(xtal_drive), .loop_locked(loop_locked)
  );
  tps_sys_partner tps_sys_partner_inst (
    .level_req(pin_req), .gp_ctrl_in(gp_ctrl_in)
  );
  // ****
  // shared tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask
  task automatic pin(input logic v, input int n);
    @(posedge mclk);
    pin_req <= v;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wait_lock;
    for (int n = 0; n < 200 && loop_locked !== 3'h7; n++) @(posedge mclk);
    #1;
    chk("locked", loop_locked, 3'h7);
  endtask
  task automatic meas(output int p);
    int r0, r1;
    logic pv;
    r0 = -1;
    r1 = -1;
    pv = 1'b1;
    for (int n = 0; n < 400 && r1 < 0; n++) begin
      @(posedge mclk);
      #1;
      if (clock_out_a === 1'b1 && pv === 1'b0) begin
        if (r0 < 0) r0 = n;
        else r1 = n;
      end
      pv = clock_out_a;
    end
    p = r1 - r0;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    wr(8'h30, 32'hFFFF_FFFF);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      chk("reset value", rd_v, rv[i]);
    end
  endtask
  task automatic t_oe;
    wr(8'h00, 32'h05);
    pin(1'b0, 2);
    chk("oe before sync", clock_out_a_oe, 1'b1);
    @(posedge mclk);
    #1;
    chk("oe low", {clock_out_a_oe, clock_out_b_oe, clock_out_c_oe}, 3'h0);
    pin(1'b1, 3);
    chk("oe high", {clock_out_a_oe, clock_out_b_oe, clock_out_c_oe}, 3'h7);
  endtask
  task automatic t_shut;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h2A);
    wr(8'h00, 32'h67);
    wait_lock;
    chk("drive", xtal_drive, 2'h3);
    chk("load", {xtal_load_en, xtal_load}, 7'h6A);
    pin(1'b0, 4);
    chk("shutdown", {osc_enable, xtal_load_en, loop_locked}, 5'h00);
    pin(1'b1, 4);
    chk("relock wait", loop_locked, 3'h0);
    wait_lock;
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h11);
    repeat (2) @(posedge mclk);
    #1;
    chk("bypass", {osc_enable, xtal_load_en, xtal_load}, 8'h80);
  endtask
  task automatic t_clk;
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h40002);
    wr(8'h18, 32'h30303);
    wr(8'h00, 32'h01);
    wait_lock;
    meas(per);
    chk("loop3 div3 period", per, 32'h0C);
    chk("b c ref div1", {clock_out_b, clock_out_c}, 2'h3);
  endtask
  task automatic t_fs;
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h40001);
    wr(8'h18, 32'h20402);
    wr(8'h00, 32'h01);
    wait_lock;
    meas(per);
    chk("fs high period", per, 32'h08);
    @(posedge mclk);
    pin_req <= 1'b0;
    meas(per);
    chk("fs whole period", per == 4 || per == 8, 1'b1);
    meas(per);
    chk("fs low period", per, 32'h04);
    pin(1'b1, 3);
  endtask
  task automatic t_susp(input logic [31:0] ctrl);
    wr(8'h00, 32'h0);
    wr(8'h24, 32'h20);
    wr(8'h00, ctrl);
    wr(8'h24, 32'h70);
    rd(8'h24);
    chk("write while running", rd_v, 32'h20);
    pin(1'b0, 4);
    chk("suspend b", {clock_out_a_oe, clock_out_b_oe, clock_out_c_oe}, 3'h5);
    pin(1'b1, 4);
    chk("resume b", {clock_out_a_oe, clock_out_b_oe, clock_out_c_oe}, 3'h7);
  endtask
  initial begin
    #(40 * 20000);
    n_errors++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    t_regs;
    t_oe;
    t_shut;
    t_clk;
    t_fs;
    t_susp(32'h03);
    t_susp(32'h09);
    stop_test;
  end
endmodule // tps_clock_synth_bench
`default_nettype wire
